// File: rtl/vector_and_table_read_unit.sv
// Vector selection for reset and interrupts, and the table read unit.
// Assumes one clock; interrupt pins arrive asynchronously, the rest
// comes from logic on core_clk.
//
// Overview of operation
// - Reset loads program counter with 000H.
// - First external pin edge vectors to 004H.
// - Second external pin edge vectors to 008H.
// - Timer 0 overflow vectors to 00CH.
// - Timer 1 overflow vectors to 010H.
// - Serial interface request vectors to 014H.
// - Five shared sources vector to 018H.
// - Full stack records flag, withholds acknowledge.
// - Push program counter before loading vector.
// - Table pointer gives low eight address bits.
// - Current page uses program counter upper bits.
// - Last page forces upper bits to one.
// - Address width 13, 12 or 11 bits.
// - Low byte goes to operand data register.
// - High byte to holding register, unused zero.
// - Holding register is read only to software.
// - Table read takes two instruction cycles.
`include "vtr_defines.svh"
module vector_and_table_read_unit
	import vtr_pkg::*;
#(
	parameter int PC_W = `VTR_PC_W,
	parameter int WORD_W = `VTR_WORD_W,
	parameter bit EXT_RISE = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic ext_irq_first,
	input wire logic ext_irq_second,
	input wire logic ext_irq_first_en,
	input wire logic ext_irq_second_en,
	input wire logic timer0_ovf,
	input wire logic timer0_en,
	input wire logic timer1_ovf,
	input wire logic timer1_en,
	input wire logic serial_req,
	input wire logic serial_en,
	input wire logic [`VTR_NUM_MF-1:0] mf_evt,
	input wire logic [`VTR_NUM_MF-1:0] mf_en,
	input wire logic [`VTR_NUM_FLAG-1:0] flag_clr,
	input wire logic irq_global_en,
	input wire logic stack_full,
	input wire logic [PC_W-1:0] cur_pc,
	input wire logic tbl_req,
	input wire logic tbl_last_page,
	input wire logic [`VTR_PTR_W-1:0] tbl_ptr,
	input wire logic [7:0] tbl_dest,
	input wire logic [15:0] pm_data,
	output logic pc_load,
	output logic [PC_W-1:0] pc_load_addr,
	output logic stack_push,
	output logic [PC_W-1:0] push_pc,
	output logic [`VTR_NUM_FLAG-1:0] irq_flags,
	output logic pm_rd,
	output logic [PC_W-1:0] pm_addr,
	output logic dm_we,
	output logic [7:0] dm_addr,
	output logic [7:0] dm_wdata,
	output logic [7:0] table_high_byte,
	output logic tbl_busy
);
	localparam int NV = `VTR_NUM_VEC;
	localparam int NF = `VTR_NUM_FLAG;
	localparam int NM = `VTR_NUM_MF;
	localparam logic [3:0] TBL_LAST = 4'(`VTR_TBL_CLKS - 1);
	// Bits of the high byte that exist in the program word
	localparam logic [7:0] HI_MASK = 8'(8'hFF >> (16 - WORD_W));

	logic rst_m_r, rst_sync_n;
	logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic [NF-1:0] flag_r, src_set, en_all, ack_clr;
	logic [NV-1:0] req_vec, lower_mask;
	logic [2:0] sel, vec_sel_r;
	logic any_req, ack_go;
	irq_state_t irq_st_r;
	tbl_state_t tbl_st_r;
	logic [3:0] tbl_cnt_r;
	logic tbl_last_r;
	logic pc_load_r, stack_push_r, pm_rd_r, dm_we_r, tbl_busy_r;
	logic [PC_W-1:0] pc_load_addr_r, push_pc_r, pm_addr_r, tbl_addr;
	logic [7:0] dm_addr_r, dm_wdata_r, thb_r;

	// Lowest index pending wins
	function automatic logic [2:0] prio(input logic [NV-1:0] r);
		logic [2:0] p;
		p = 3'h0;
		for (int i = NV - 1; i >= 0; i--) begin
			if (r[i]) begin
				p = 3'(i);
			end
		end
		return p;
	endfunction : prio

	// Vector address for each request index
	function automatic logic [PC_W-1:0] vec_addr(input logic [2:0] i);
		logic [12:0] a;
		case (i)
			3'h0: a = `VTR_VEC_EXT0;
			3'h1: a = `VTR_VEC_EXT1;
			3'h2: a = `VTR_VEC_TMR0;
			3'h3: a = `VTR_VEC_TMR1;
			3'h4: a = `VTR_VEC_SER;
			3'h5: a = `VTR_VEC_MF;
			default: a = `VTR_VEC_RESET;
		endcase
		return a[PC_W-1:0];
	endfunction : vec_addr

	// Reset release through two flip-flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_sync_n <= rst_m_r;
		end
	end

	// Pin synchronisers and edge history
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			always_ff @(posedge core_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					pin_s1_r[g] <= ~EXT_RISE;
					pin_s2_r[g] <= ~EXT_RISE;
					pin_s3_r[g] <= ~EXT_RISE;
				end else if (clk_en) begin
					pin_s1_r[g] <= g == 0 ? ext_irq_first : ext_irq_second;
					pin_s2_r[g] <= pin_s1_r[g];
					pin_s3_r[g] <= pin_s2_r[g];
				end
			end
		end
	endgenerate

	// Event sources and enables, flag order by vector
	always_comb begin
		src_set[0] = (pin_s2_r[0] ^ pin_s3_r[0]) & (pin_s2_r[0] == EXT_RISE);
		src_set[1] = (pin_s2_r[1] ^ pin_s3_r[1]) & (pin_s2_r[1] == EXT_RISE);
		src_set[2] = timer0_ovf;
		src_set[3] = timer1_ovf;
		src_set[4] = serial_req;
		src_set[NF-1:5] = mf_evt;
		en_all = {mf_en, serial_en, timer1_en, timer0_en,
			ext_irq_second_en, ext_irq_first_en};
	end

	// Per-vector requests; shared vector ORs its sources
	always_comb begin
		req_vec[4:0] = flag_r[4:0] & en_all[4:0];
		req_vec[5] = |(flag_r[NF-1:5] & en_all[NF-1:5]);
		any_req = (|req_vec) & irq_global_en;
		sel = prio(req_vec);
		lower_mask = NV'((7'h01 << vec_sel_r) - 7'h01);
		// Withheld while the stack is full or a table read runs
		ack_go = (irq_st_r == I_IDLE) & any_req & ~stack_full
			& ~tbl_busy_r & ~tbl_req;
		ack_clr = '0;
		if (ack_go) begin
			if (sel < 3'h5) begin
				ack_clr[sel] = 1'b1;
			end else begin
				ack_clr[NF-1:5] = flag_r[NF-1:5] & en_all[NF-1:5];
			end
		end
	end

	// Sticky request flags; a set beats any clear
	generate
		for (g = 0; g < NF; g++) begin : g_flag
			always_ff @(posedge core_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					flag_r[g] <= 1'b0;
				end else if (clk_en) begin
					flag_r[g] <= src_set[g]
						| (flag_r[g] & ~(flag_clr[g] | ack_clr[g]));
				end
			end
		end
	endgenerate

	// Reset vector, then push and vector load on acknowledge
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_st_r <= I_RESET;
			pc_load_r <= 1'b0;
			pc_load_addr_r <= '0;
			stack_push_r <= 1'b0;
			push_pc_r <= '0;
			vec_sel_r <= 3'h0;
		end else if (clk_en) begin
			pc_load_r <= 1'b0;
			stack_push_r <= 1'b0;
			case (irq_st_r)
				I_RESET: begin
					pc_load_r <= 1'b1;
					pc_load_addr_r <= PC_W'(`VTR_VEC_RESET);
					irq_st_r <= I_IDLE;
				end
				I_IDLE: begin
					if (ack_go) begin
						stack_push_r <= 1'b1;
						push_pc_r <= cur_pc;
						vec_sel_r <= sel;
						irq_st_r <= I_PUSH;
					end
				end
				I_PUSH: begin
					pc_load_r <= 1'b1;
					pc_load_addr_r <= vec_addr(vec_sel_r);
					irq_st_r <= I_LOAD;
				end
				I_LOAD: begin
					irq_st_r <= I_IDLE;
				end
				default: begin
					irq_st_r <= I_IDLE;
				end
			endcase
		end
	end

	// Table address: pointer low, page bits above
	always_comb begin
		tbl_addr[7:0] = tbl_ptr;
		if (tbl_last_page) begin
			tbl_addr[PC_W-1:8] = '1;
		end else begin
			tbl_addr[PC_W-1:8] = cur_pc[PC_W-1:8];
		end
	end

	// Table read over two instruction cycles
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tbl_st_r <= T_IDLE;
			tbl_cnt_r <= 4'h0;
			tbl_busy_r <= 1'b0;
			tbl_last_r <= 1'b0;
			pm_rd_r <= 1'b0;
			pm_addr_r <= '0;
			dm_we_r <= 1'b0;
			dm_addr_r <= 8'h00;
			dm_wdata_r <= 8'h00;
		end else if (clk_en) begin
			pm_rd_r <= 1'b0;
			dm_we_r <= 1'b0;
			case (tbl_st_r)
				T_IDLE: begin
					if (tbl_req && irq_st_r == I_IDLE) begin
						tbl_st_r <= T_BUSY;
						tbl_busy_r <= 1'b1;
						tbl_cnt_r <= TBL_LAST;
						tbl_last_r <= tbl_last_page;
						pm_rd_r <= 1'b1;
						pm_addr_r <= tbl_addr;
						dm_addr_r <= tbl_dest;
					end
				end
				T_BUSY: begin
					tbl_cnt_r <= tbl_cnt_r - 4'h1;
					if (tbl_cnt_r == 4'h1) begin
						dm_we_r <= 1'b1;
						dm_wdata_r <= pm_data[7:0];
					end
					if (tbl_cnt_r == 4'h0) begin
						tbl_busy_r <= 1'b0;
						tbl_st_r <= T_IDLE;
					end
				end
				default: begin
					tbl_st_r <= T_IDLE;
				end
			endcase
		end
	end

	// High byte holder; no software write path exists
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			thb_r <= 8'h00;
		end else if (clk_en && tbl_st_r == T_BUSY && tbl_cnt_r == 4'h1) begin
			thb_r <= pm_data[15:8] & HI_MASK;
		end
	end

	// Outputs straight from flip-flops
	assign pc_load = pc_load_r;
	assign pc_load_addr = pc_load_addr_r;
	assign stack_push = stack_push_r;
	assign push_pc = push_pc_r;
	assign irq_flags = flag_r;
	assign pm_rd = pm_rd_r;
	assign pm_addr = pm_addr_r;
	assign dm_we = dm_we_r;
	assign dm_addr = dm_addr_r;
	assign dm_wdata = dm_wdata_r;
	assign table_high_byte = thb_r;
	assign tbl_busy = tbl_busy_r;

	// Checks on the sequencers
	sequence s_push_then_load;
		stack_push_r ##1 pc_load_r;
	endsequence
	sequence s_busy_run;
		tbl_busy_r [*8] ##1 !tbl_busy_r;
	endsequence

	a_reset_vector: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		$rose(rst_sync_n) |-> ##[0:1] (pc_load_r && pc_load_addr_r == '0))
		else $error("reset vector not loaded");
	a_push_load: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		stack_push_r |-> s_push_then_load)
		else $error("push not followed by load");
	a_vector_map: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		s_push_then_load |-> pc_load_addr_r == PC_W'(13'h004
			+ 13'(vec_sel_r) * 13'h004))
		else $error("wrong interrupt vector");
	a_full_withheld: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		stack_push_r |-> !$past(stack_full))
		else $error("acknowledge while stack full");
	a_flag_kept: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		($past(src_set) & ~flag_r) == '0)
		else $error("request flag lost");
	a_lowest_first: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		$rose(stack_push_r) |-> ($past(req_vec) & lower_mask) == '0)
		else $error("lower vector bypassed");
	a_ptr_low: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		pm_rd_r |-> pm_addr_r[7:0] == $past(tbl_ptr))
		else $error("table pointer not in address");
	a_page_bits: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		pm_rd_r |-> pm_addr_r[PC_W-1:8] == (tbl_last_r ? '1
			: $past(cur_pc[PC_W-1:8])))
		else $error("table page bits wrong");
	a_two_instr: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		$rose(tbl_busy_r) |-> s_busy_run)
		else $error("table read length wrong");
	a_low_byte: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		dm_we_r |-> dm_wdata_r == $past(pm_data[7:0]) && tbl_busy_r)
		else $error("low byte not written");
	a_high_byte: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		dm_we_r |-> thb_r == ($past(pm_data[15:8]) & HI_MASK))
		else $error("high byte wrong");
	a_high_hold: assert property (@(posedge core_clk)
		disable iff (!rst_sync_n || !clk_en)
		$changed(thb_r) |-> dm_we_r)
		else $error("high byte changed outside table read");
endmodule : vector_and_table_read_unit

// File: rtl/vtr_defines.svh
// Constants for the vector and table read unit.
// Assumes inclusion by bare name from the rtl folder.
`ifndef VTR_DEFINES_SVH
`define VTR_DEFINES_SVH
// Fixed program memory vectors
`define VTR_VEC_RESET 13'h000
`define VTR_VEC_EXT0 13'h004
`define VTR_VEC_EXT1 13'h008
`define VTR_VEC_TMR0 13'h00C
`define VTR_VEC_TMR1 13'h010
`define VTR_VEC_SER 13'h014
`define VTR_VEC_MF 13'h018
// Address and word widths, largest variant
`define VTR_PC_W 13
`define VTR_WORD_W 16
`define VTR_PTR_W 8
// Source counts
`define VTR_NUM_VEC 6
`define VTR_NUM_MF 5
`define VTR_NUM_FLAG 10
// Timing: system clocks per instruction cycle
`define VTR_INSTR_CLKS 4
`define VTR_TBL_INSTRS 2
`define VTR_TBL_CLKS (`VTR_INSTR_CLKS * `VTR_TBL_INSTRS)
`endif

// File: rtl/vtr_pkg.sv
// Types shared by the vector and table read unit.
// Assumes nothing of its surroundings.
package vtr_pkg;
	// Interrupt entry sequencer
	typedef enum logic [1:0] {
		I_RESET = 2'b00,
		I_IDLE = 2'b01,
		I_PUSH = 2'b10,
		I_LOAD = 2'b11
	} irq_state_t;
	// Table read sequencer
	typedef enum logic [0:0] {
		T_IDLE = 1'b0,
		T_BUSY = 1'b1
	} tbl_state_t;
endpackage : vtr_pkg

// File: verif/pm_model.sv
// Program memory model answering table read fetches.
// Assumes pm_rd is a one-cycle pulse with pm_addr valid in that cycle.
module pm_model (
	input wire logic core_clk,
	input wire logic pm_rd,
	input wire logic [12:0] pm_addr,
	output logic [15:0] pm_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold_r;
	initial begin
		hold_r = 4'h0;
		pm_data = 16'h0000;
	end
	// Word holds eight cycles after a fetch, then toggles every cycle
	always @(posedge core_clk) begin
		if (pm_rd) begin
			pm_data <= {~pm_addr[7:0] ^ {3'b000, pm_addr[12:8]},
				pm_addr[7:0] ^ 8'h5A};
			hold_r <= 4'h8;
		end else if (hold_r != 4'h0) begin
			hold_r <= hold_r - 4'h1;
		end else begin
			pm_data <= ~pm_data; // Stale data equals the fetched word only on alternate cycles
		end
	end
endmodule : pm_model

// File: verif/tb.sv
// Self-checking bench for the vector and table read unit.
// Assumes the unit at its default widths and pm_model as memory.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_n = 0, clk_en = 1;
	logic ext_irq_first = 0, ext_irq_second = 0;
	logic ext_irq_first_en = 1, ext_irq_second_en = 1;
	logic timer0_ovf = 0, timer0_en = 1, timer1_ovf = 0, timer1_en = 1;
	logic serial_req = 0, serial_en = 1, irq_global_en = 0;
	logic stack_full = 0, tbl_req = 0, tbl_last_page = 0;
	logic [4:0] mf_evt = 5'h00, mf_en = 5'h1F;
	logic [9:0] flag_clr = 10'h000;
	logic [12:0] cur_pc = 13'h0ABC;
	logic [7:0] tbl_ptr = 8'h00, tbl_dest = 8'h00;
	logic [15:0] pm_data;
	logic pc_load, stack_push, pm_rd, dm_we, tbl_busy;
	logic [12:0] pc_load_addr, push_pc, pm_addr;
	logic [9:0] irq_flags;
	logic [7:0] dm_addr, dm_wdata, table_high_byte, thb_saved;
	int n_mismatch = 0, check_count = 0;

	vector_and_table_read_unit dut (.core_clk, .rst_n, .clk_en,
		.ext_irq_first, .ext_irq_second, .ext_irq_first_en,
		.ext_irq_second_en, .timer0_ovf, .timer0_en, .timer1_ovf,
		.timer1_en, .serial_req, .serial_en, .mf_evt, .mf_en, .flag_clr,
		.irq_global_en, .stack_full, .cur_pc, .tbl_req, .tbl_last_page,
		.tbl_ptr, .tbl_dest, .pm_data, .pc_load, .pc_load_addr,
		.stack_push, .push_pc, .irq_flags, .pm_rd, .pm_addr, .dm_we,
		.dm_addr, .dm_wdata, .table_high_byte, .tbl_busy);
	pm_model mem (.core_clk, .pm_rd, .pm_addr, .pm_data);

	// Free-running 40 MHz clock
	always #12.5 core_clk = ~core_clk;

	task chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task close_out;
		$display("Checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// Sample one step after a rising edge
	task step;
		@(posedge core_clk);
		#1;
	endtask : step

	// One-cycle event pulse; bits follow the flag order
	task fire(input logic [9:0] m);
		@(negedge core_clk);
		{mf_evt, serial_req, timer1_ovf, timer0_ovf, ext_irq_second,
			ext_irq_first} = m;
		@(negedge core_clk);
		{mf_evt, serial_req, timer1_ovf, timer0_ovf, ext_irq_second,
			ext_irq_first} = 10'h000;
	endtask : fire

	// Open the global enable and expect push then vector load
	task entry(input logic [12:0] vec);
		int i;
		@(negedge core_clk);
		irq_global_en = 1;
		for (i = 0; i < 12 && stack_push !== 1'b1; i++)
			step;
		chk("stack_push", 16'h0001, 16'(stack_push));
		chk("push_pc", 16'(cur_pc), 16'(push_pc));
		step;
		chk("pc_load", 16'h0001, 16'(pc_load));
		chk("pc_load_addr", 16'(vec), 16'(pc_load_addr));
		@(negedge core_clk);
		irq_global_en = 0;
	endtask : entry

	task no_entry;
		int pushes;
		pushes = 0;
		repeat (12) begin
			step;
			if (stack_push === 1'b1)
				pushes++;
		end
		chk("no stack_push", 16'h0000, 16'(pushes));
	endtask : no_entry

	task t_table(input logic last, input logic [7:0] ptr,
		input logic [7:0] dest);
		int n;
		logic [12:0] a;
		logic [7:0] hi;
		a = last ? {5'h1F, ptr} : {cur_pc[12:8], ptr};
		hi = ~a[7:0] ^ {3'b000, a[12:8]};
		@(negedge core_clk);
		irq_global_en = 0;
		tbl_req = 1;
		tbl_last_page = last;
		tbl_ptr = ptr;
		tbl_dest = dest;
		for (n = 0; n < 12 && pm_rd !== 1'b1; n++)
			step;
		chk("pm_rd", 16'h0001, 16'(pm_rd));
		chk("pm_addr", 16'(a), 16'(pm_addr));
		chk("busy during read", 16'h0001, 16'(tbl_busy));
		@(negedge core_clk);
		tbl_req = 0;
		n = 1;
		while (dm_we !== 1'b1 && n < 12) begin
			step;
			n++;
		end
		chk("table cycles", 16'h0008, 16'(n));
		chk("dm_addr", 16'(dest), 16'(dm_addr));
		chk("dm_wdata", 16'(a[7:0] ^ 8'h5A), 16'(dm_wdata));
		chk("table_high_byte", 16'(hi), 16'(table_high_byte));
		step;
		chk("tbl_busy", 16'h0000, 16'(tbl_busy));
	endtask : t_table

	// Watchdog cuts a hang short
	initial begin
		repeat (4000) @(posedge core_clk);
		n_mismatch++;
		close_out;
	end

	// Main sequence
	initial begin
		int i;
		logic [12:0] vec;
		repeat (2) @(negedge core_clk);
		rst_n = 1;
		for (i = 0; i < 6 && pc_load !== 1'b1; i++)
			step;
		chk("reset pc_load", 16'h0001, 16'(pc_load));
		chk("reset vector", 16'h0000, 16'(pc_load_addr));
		t_table(1'b0, 8'h06, 8'h40);
		t_table(1'b1, 8'hFF, 8'h41);
		thb_saved = table_high_byte;
		for (i = 0; i < 10; i++) begin
			fire(10'h001 << i);
			vec = i < 5 ? 13'(4 * (i + 1)) : 13'h018;
			entry(vec);
		end
		fire(10'h02C);
		entry(13'h00C);
		entry(13'h010);
		entry(13'h018);
		chk("held high byte", 16'(thb_saved), 16'(table_high_byte));
		@(negedge core_clk);
		stack_full = 1;
		fire(10'h008);
		@(negedge core_clk);
		irq_global_en = 1;
		no_entry;
		chk("pending flag", 16'h0001, 16'(irq_flags[3]));
		@(negedge core_clk);
		stack_full = 0;
		entry(13'h010);
		@(negedge core_clk);
		timer0_en = 0;
		fire(10'h004);
		@(negedge core_clk);
		irq_global_en = 1;
		no_entry;
		chk("masked flag", 16'h0001, 16'(irq_flags[2]));
		@(negedge core_clk);
		irq_global_en = 0;
		flag_clr = 10'h004;
		@(negedge core_clk);
		flag_clr = 10'h000;
		timer0_en = 1;
		chk("cleared flag", 16'h0000, 16'(irq_flags[2]));
		// Frozen clock enable drops events
		clk_en = 0;
		fire(10'h008);
		chk("frozen flag", 16'h0000, 16'(irq_flags[3]));
		@(negedge core_clk);
		clk_en = 1;
		close_out;
	end
endmodule : tb
